// File: hdl/pid_loop_pkg.sv
package pid_loop_pkg;
  // clock and sample timing
  localparam int CLK_MHZ = 100;
  localparam int SAMPLE_US = 1000;
  localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
  localparam int TICK_W = 17;
  localparam int TIME_LSB_US = 10000;
  localparam int DET_LSB_US = 100000;
  localparam int DET_TICKS = DET_LSB_US / SAMPLE_US;
  localparam int D_SCALE = TIME_LSB_US / SAMPLE_US;
  // fixed point: signals in 0.01 %, limits and bias in 0.1 %, levels in 1 %
  localparam int GAIN_ONE = 100;
  localparam int PCT10 = 10;
  localparam int PCT1 = 100;
  localparam int FULL_SCALE = 10000;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_DEV = 3'h1,
    MODE_FB2 = 3'h2,
    MODE_ADD_DEV = 3'h3,
    MODE_ADD_FB2 = 3'h4
  } mode_t;

  // supervision selections with special actions
  localparam logic [2:0] SUP_ALARM = 3'h1;
  localparam logic [2:0] SUP_FAULT = 3'h2;
  localparam logic [2:0] SUP_KEEP_LO = 3'h3;
  localparam logic [2:0] SUP_ALARM_KEEP = 3'h4;
  localparam logic [2:0] SUP_FAULT_KEEP = 3'h5;
  localparam logic [2:0] SUP_STOPPED = 3'h7;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KP = 8'h04;
  localparam logic [7:0] ADDR_TI = 8'h08;
  localparam logic [7:0] ADDR_ILIM = 8'h0C;
  localparam logic [7:0] ADDR_TD = 8'h10;
  localparam logic [7:0] ADDR_CEIL = 8'h14;
  localparam logic [7:0] ADDR_BIAS = 8'h18;
  localparam logic [7:0] ADDR_TF = 8'h1C;
  localparam logic [7:0] ADDR_KOUT = 8'h20;
  localparam logic [7:0] ADDR_LO_LVL = 8'h24;
  localparam logic [7:0] ADDR_LO_TIME = 8'h28;
  localparam logic [7:0] ADDR_HI_LVL = 8'h2C;
  localparam logic [7:0] ADDR_HI_TIME = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_DEV = 8'h38;
  localparam logic [7:0] ADDR_FB2 = 8'h3C;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INV_BIT = 3;
  localparam int CTRL_REV_BIT = 4;
  localparam int CTRL_SUP_LSB = 5;
  localparam int CTRL_CLR_BIT = 8;
  // status register fields
  localparam int ST_LOW_BIT = 0;
  localparam int ST_HIGH_BIT = 1;
  localparam int ST_ALARM_BIT = 2;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_REV_BIT = 4;

  // reset values
  localparam logic [15:0] GAIN_RST = 16'h0064;
  localparam logic [15:0] PCT_FULL_RST = 16'h03E8;
  localparam logic [7:0] LVL_HI_RST = 8'h64;
  localparam logic [7:0] DET_TIME_RST = 8'h0A;
endpackage

// File: hdl/pid_speed_loop.sv
`timescale 1ns/1ps
// Overview of operation
// - mode 0..4, reset 0; mode 0 bypasses the regulator entirely
// - mode 1: output is regulator only, derivative on deviation
// - mode 2: output is regulator only, derivative on second feedback
// - modes 3/4 add regulator to command; derivative on deviation / feedback 2
// - proportional gain 0.00..25.00, reset 1.00, times deviation
// - integrate deviation over integral time; zero time disables integral
// - integral term clamped to 0.0..100.0 % limit, reset 100.0 %
// - derivative scaled by 0.00..10.00 s time; zero disables it
// - regulator output limited to 0.0..100.0 % ceiling, reset 100.0 %
// - signed bias -100.0..100.0 % added, reset 0.0 %
// - first-order output filter 0.00..10.00 s; zero bypasses it
// - polarity 0 keeps sign, 1 inverts regulator action
// - output gain 0.00..25.00, reset 1.00
// - reversal off: negative output clamps to zero, drive stops
// - reversal on: negative output commands reverse rotation
// - low detect after feedback below level longer than low time
// - high detect after feedback above level longer than high time
// - selection 0: indication outputs only, cleared on return to range
// - selection 1: alarm plus indications, cleared on return to range
// - selection 2: fault raised and motor stopped
// - selections 3..5 like 0..2 but active while regulator disabled by input
// - detection times 0.0..25.5 s, reset 1.0 s
// - levels 0..100 %, high reset 100 %, low reset 0 %
// - selection 7 like 0 but detects only while drive is stopped
module pid_speed_loop
  import pid_loop_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES_P = pid_loop_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  // process inputs, the 16-bit ones in 0.01 % of maximum frequency
  input wire logic [15:0] target_i,
  input wire logic [15:0] feedback_i,
  input wire logic [15:0] feedback2_i,
  input wire logic [15:0] freq_cmd_i,
  input wire logic run_i,
  input wire logic pid_disable_i,
  // drive side
  output logic [15:0] freq_o,
  output logic reverse_o,
  output logic low_feedback_event_o,
  output logic high_feedback_event_o,
  output logic alarm_o,
  output logic fault_o
);
  import pid_loop_pkg::*;

  typedef struct packed {
    logic [2:0] regulator_mode_select;
    logic output_polarity_invert;
    logic negative_output_reverse_enable;
    logic [2:0] feedback_supervision_select;
    logic [15:0] proportional_gain;
    logic [15:0] integral_time;
    logic [15:0] integral_term_limit;
    logic [15:0] derivative_time;
    logic [15:0] regulator_output_ceiling;
    logic [15:0] regulator_output_bias;
    logic [15:0] output_filter_time;
    logic [15:0] regulator_output_gain;
    logic [1:0][7:0] feedback_level;
    logic [1:0][7:0] feedback_time;
    logic [TICK_W-1:0] tick_cnt;
    logic [31:0] acc;
    logic [31:0] x_prev;
    logic [31:0] y;
    logic [15:0] deviation_monitor;
    logic [1:0][15:0] det_cnt;
    logic [1:0] event_out;
    logic alarm;
    logic fault;
    logic rev;
    logic [15:0] freq;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic tick;
  logic pid_on;
  logic det_act;
  logic fault_set;
  logic [1:0] cond;
  logic [1:0] qual;
  logic signed [31:0] dev, xin, iraw, pterm, iterm, dterm, sum, lim_out;
  logic signed [31:0] scaled, biased, filt, total, fbv;

  function automatic logic signed [31:0] u32(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lim);
    if (v > lim) return lim;
    if (v < -lim) return -lim;
    return v;
  endfunction

  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    tick = (s.tick_cnt == TICK_W'(SAMPLE_CYCLES_P - 1));
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
    pid_on = (s.regulator_mode_select != MODE_OFF) && !pid_disable_i;
    // deviation and derivative source
    dev = u32(target_i) - u32(feedback_i);
    if (s.regulator_mode_select == MODE_FB2 || s.regulator_mode_select == MODE_ADD_FB2) begin
      xin = -u32(feedback2_i);
    end else begin
      xin = dev;
    end
    pterm = u32(s.proportional_gain) * dev / GAIN_ONE;
    if (s.integral_time == 16'h0000) begin
      iraw = 32'sh0000_0000;
    end else begin
      // divide by the time in ticks; scaling the sum up first would overflow it
      iraw = $signed(s.acc) / (u32(s.integral_time) * D_SCALE);
    end
    iterm = clamp(iraw, u32(s.integral_term_limit) * PCT10);
    // a step in the derivative source kicks the output for one sample only
    dterm = u32(s.derivative_time) * (xin - $signed(s.x_prev)) * D_SCALE;
    sum = pterm + iterm + dterm;
    if (s.output_polarity_invert) begin
      sum = -sum;
    end
    lim_out = clamp(sum, u32(s.regulator_output_ceiling) * PCT10);
    scaled = lim_out * u32(s.regulator_output_gain) / GAIN_ONE;
    biased = scaled + $signed({{16{s.regulator_output_bias[15]}},
                                s.regulator_output_bias}) * PCT10;
    if (s.output_filter_time == 16'h0000) begin
      filt = biased;
    end else begin
      // truncation leaves the output a fraction of a step short of its goal
      filt = $signed(s.y) + (biased - $signed(s.y))
             / (u32(s.output_filter_time) * D_SCALE);
    end
    if (!pid_on) begin
      total = u32(freq_cmd_i);
    end else if (s.regulator_mode_select >= MODE_ADD_DEV) begin
      total = u32(freq_cmd_i) + filt;
    end else begin
      total = filt;
    end
    if (tick) begin
      next_s.deviation_monitor = dev[15:0];
      if (pid_on) begin
        next_s.y = filt;
        next_s.x_prev = xin;
        // integrate inside the limit, or when the deviation pulls the term back in
        if (s.integral_time != 16'h0000
            && (iraw == iterm || ((iraw > iterm) != (dev > 0)))) begin
          next_s.acc = s.acc + dev;
        end
      end else begin
        next_s.y = 32'h0000_0000;
        next_s.x_prev = xin;
        next_s.acc = 32'h0000_0000;
      end
      if (s.fault) begin
        next_s.freq = 16'h0000;
        next_s.rev = 1'b0;
      end else if (total < 0) begin
        next_s.rev = s.negative_output_reverse_enable && pid_on;
        next_s.freq = next_s.rev ? 16'(clamp(-total, FULL_SCALE)) : 16'h0000;
      end else begin
        next_s.rev = 1'b0;
        next_s.freq = 16'(clamp(total, FULL_SCALE));
      end
    end
    // feedback supervision; index 0 low, index 1 high
    fbv = u32(feedback_i);
    if (s.feedback_supervision_select == SUP_STOPPED) begin
      det_act = !run_i;
    end else if (s.feedback_supervision_select >= SUP_KEEP_LO
                 && s.feedback_supervision_select <= SUP_FAULT_KEEP) begin
      det_act = run_i;
    end else begin
      det_act = run_i && pid_on;
    end
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        cond[k] = fbv < u32({8'h00, s.feedback_level[k]}) * PCT1;
      end else begin
        cond[k] = fbv > u32({8'h00, s.feedback_level[k]}) * PCT1;
      end
      qual[k] = det_act && cond[k] && u32(s.det_cnt[k])
                > u32({8'h00, s.feedback_time[k]}) * DET_TICKS;
      if (!det_act || !cond[k]) begin
        next_s.det_cnt[k] = 16'h0000;
      end else if (tick && !qual[k]) begin
        next_s.det_cnt[k] = s.det_cnt[k] + 1'b1;
      end
    end
    fault_set = 1'b0;
    next_s.alarm = 1'b0;
    next_s.event_out = 2'b00;
    case (s.feedback_supervision_select)
      SUP_FAULT, SUP_FAULT_KEEP: begin
        fault_set = |qual;
      end
      SUP_ALARM, SUP_ALARM_KEEP: begin
        next_s.event_out = qual;
        next_s.alarm = |qual;
      end
      default: begin
        next_s.event_out = qual;
      end
    endcase
    // fault is sticky; a new event in the clear cycle wins
    if (wr_en_i && addr_i == ADDR_CTRL && wr_data_i[CTRL_CLR_BIT]) begin
      next_s.fault = fault_set;
    end else begin
      next_s.fault = s.fault | fault_set;
    end
    if (wr_en_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          // out-of-range modes are refused and the old mode kept
          if (wr_data_i[CTRL_MODE_LSB +: 3] <= MODE_ADD_FB2) begin
            next_s.regulator_mode_select = wr_data_i[CTRL_MODE_LSB +: 3];
          end
          next_s.output_polarity_invert = wr_data_i[CTRL_INV_BIT];
          next_s.negative_output_reverse_enable = wr_data_i[CTRL_REV_BIT];
          next_s.feedback_supervision_select = wr_data_i[CTRL_SUP_LSB +: 3];
        end
        ADDR_KP: next_s.proportional_gain = wr_data_i[15:0];
        ADDR_TI: next_s.integral_time = wr_data_i[15:0];
        ADDR_ILIM: next_s.integral_term_limit = wr_data_i[15:0];
        ADDR_TD: next_s.derivative_time = wr_data_i[15:0];
        ADDR_CEIL: next_s.regulator_output_ceiling = wr_data_i[15:0];
        ADDR_BIAS: next_s.regulator_output_bias = wr_data_i[15:0];
        ADDR_TF: next_s.output_filter_time = wr_data_i[15:0];
        ADDR_KOUT: next_s.regulator_output_gain = wr_data_i[15:0];
        ADDR_LO_LVL: next_s.feedback_level[0] = wr_data_i[7:0];
        ADDR_LO_TIME: next_s.feedback_time[0] = wr_data_i[7:0];
        ADDR_HI_LVL: next_s.feedback_level[1] = wr_data_i[7:0];
        ADDR_HI_TIME: next_s.feedback_time[1] = wr_data_i[7:0];
        default: begin
        end
      endcase
    end
    if (rd_en_i) begin
      case (addr_i)
        ADDR_CTRL: next_s.rdata = {23'h0, 1'b0, s.feedback_supervision_select,
                                   s.negative_output_reverse_enable,
                                   s.output_polarity_invert, s.regulator_mode_select};
        ADDR_KP: next_s.rdata = {16'h0000, s.proportional_gain};
        ADDR_TI: next_s.rdata = {16'h0000, s.integral_time};
        ADDR_ILIM: next_s.rdata = {16'h0000, s.integral_term_limit};
        ADDR_TD: next_s.rdata = {16'h0000, s.derivative_time};
        ADDR_CEIL: next_s.rdata = {16'h0000, s.regulator_output_ceiling};
        ADDR_BIAS: next_s.rdata = {16'h0000, s.regulator_output_bias};
        ADDR_TF: next_s.rdata = {16'h0000, s.output_filter_time};
        ADDR_KOUT: next_s.rdata = {16'h0000, s.regulator_output_gain};
        ADDR_LO_LVL: next_s.rdata = {24'h00_0000, s.feedback_level[0]};
        ADDR_LO_TIME: next_s.rdata = {24'h00_0000, s.feedback_time[0]};
        ADDR_HI_LVL: next_s.rdata = {24'h00_0000, s.feedback_level[1]};
        ADDR_HI_TIME: next_s.rdata = {24'h00_0000, s.feedback_time[1]};
        ADDR_STATUS: begin
          next_s.rdata[ST_LOW_BIT] = s.event_out[0];
          next_s.rdata[ST_HIGH_BIT] = s.event_out[1];
          next_s.rdata[ST_ALARM_BIT] = s.alarm;
          next_s.rdata[ST_FAULT_BIT] = s.fault;
          next_s.rdata[ST_REV_BIT] = s.rev;
        end
        ADDR_DEV: next_s.rdata = {{16{s.deviation_monitor[15]}}, s.deviation_monitor};
        ADDR_FB2: next_s.rdata = {16'h0000, feedback2_i};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
      s.proportional_gain <= GAIN_RST;
      s.integral_term_limit <= PCT_FULL_RST;
      s.regulator_output_ceiling <= PCT_FULL_RST;
      s.regulator_output_gain <= GAIN_RST;
      s.feedback_level[1] <= LVL_HI_RST;
      s.feedback_time[0] <= DET_TIME_RST;
      s.feedback_time[1] <= DET_TIME_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rdata;
  assign freq_o = s.freq;
  assign reverse_o = s.rev;
  assign low_feedback_event_o = s.event_out[0];
  assign high_feedback_event_o = s.event_out[1];
  assign alarm_o = s.alarm;
  assign fault_o = s.fault;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  mode_off_pass_a: assert property ((tick && !pid_on && !s.fault) |=>
    (freq_o == $past(freq_cmd_i) && !reverse_o))
    else $error("disabled regulator did not pass the command through");
  fault_stops_a: assert property ((tick && s.fault) |=> (freq_o == 16'h0000))
    else $error("fault did not stop the drive");
  no_reverse_a: assert property ($rose(reverse_o) |->
    $past(s.negative_output_reverse_enable))
    else $error("reverse commanded while reversal disabled");
  integ_off_a: assert property ((s.integral_time == 16'h0000) |-> (iterm == 0))
    else $error("integral active with zero time");
  low_qualify_a: assert property ($rose(low_feedback_event_o) |->
    $past(u32(s.det_cnt[0]) > u32({8'h00, s.feedback_time[0]}) * DET_TICKS))
    else $error("low event before its time elapsed");
  timer_restart_a: assert property ((!cond[1]) |=> (s.det_cnt[1] == 16'h0000))
    else $error("high timer not restarted");
  alarm_pair_a: assert property (alarm_o |-> (low_feedback_event_o || high_feedback_event_o))
    else $error("alarm without an indication");
  fault_set_wins_a: assert property (fault_set |=> fault_o)
    else $error("fault event lost");
  ceiling_hold_a: assert property ((tick && pid_on && !s.fault
    && s.regulator_mode_select <= MODE_FB2 && s.output_filter_time == 16'h0000
    && s.regulator_output_gain == GAIN_RST && s.regulator_output_bias == 16'h0000) |=>
    (u32(freq_o) <= $past(u32(s.regulator_output_ceiling)) * PCT10))
    else $error("output above ceiling");

  fault_seen_c: cover property ($rose(fault_o));
  alarm_seen_c: cover property ($rose(alarm_o));
  reverse_seen_c: cover property ($rose(reverse_o));
  high_seen_c: cover property ($rose(high_feedback_event_o));
  filter_step_c: cover property (tick && pid_on && filt != biased);
endmodule // pid_speed_loop

// File: sim/fb_sensor_model.sv
`timescale 1ns/1ps
// sensor side: feedback follows the set value, at once or slewing
module fb_sensor_model (
  // clock
  input wire logic clk_i,
  // set values from the bench
  input wire logic [15:0] fb_set_i,
  input wire logic [15:0] fb2_set_i,
  input wire logic slow_i,
  // sensor outputs
  output logic [15:0] feedback_o,
  output logic [15:0] feedback2_o
);
  logic [15:0] gap;
  initial feedback_o = 16'h0000;
  initial feedback2_o = 16'h0000;
  assign gap = (feedback_o > fb_set_i) ? feedback_o - fb_set_i : fb_set_i - feedback_o;
  // a slewing sensor crosses a level over several ticks, not in one step
  always @(posedge clk_i) begin
    feedback2_o <= fb2_set_i;
    if (!slow_i || gap <= 16'h0032) begin
      feedback_o <= fb_set_i;
    end else if (feedback_o > fb_set_i) begin
      feedback_o <= feedback_o - 16'h0032;
    end else begin
      feedback_o <= feedback_o + 16'h0032;
    end
  end
endmodule // fb_sensor_model

// File: sim/pid_speed_loop_with_feedback_check_bench.sv
`timescale 1ns/1ps
module pid_speed_loop_with_feedback_check_bench;
  import pid_loop_pkg::*;
  localparam int SP = 20;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic wr_en_i = 1'b0, rd_en_i = 1'b0, run_i = 1'b1, dis_i = 1'b0, slow = 1'b0;
  logic [15:0] target_i = 16'h0000, fb_set = 16'h0000, fb2_set = 16'h0000, cmd_i = 16'h0000;
  logic [31:0] rd_data_o, v;
  logic [15:0] freq_o, fb, fb2;
  logic reverse_o, lo_o, hi_o, alarm_o, fault_o;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 74176;
  int md, kp, ceil, kout, bias, tg, fv, cm, u, f;
  bit inv, rev, r;
  int tbl [8][5] = '{'{0, 1, 0, 1, 0}, '{1, 1, 0, 1, 1}, '{0, 1, 1, 0, 0}, '{3, 1, 1, 1, 0},
    '{4, 1, 1, 1, 1}, '{7, 0, 0, 1, 0}, '{7, 1, 0, 0, 0}, '{6, 1, 0, 1, 0}};
  logic [7:0] ra [13] = '{ADDR_CTRL, ADDR_KP, ADDR_TI, ADDR_ILIM, ADDR_TD, ADDR_CEIL, ADDR_BIAS,
    ADDR_TF, ADDR_KOUT, ADDR_LO_LVL, ADDR_LO_TIME, ADDR_HI_LVL, ADDR_HI_TIME};
  logic [31:0] rv [13] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 32'h0000_03E8,
    32'h0000_0000, 32'h0000_03E8, 32'h0000_0000, 32'h0000_0000, 32'h0000_0064, 32'h0000_0000,
    32'h0000_000A, 32'h0000_0064, 32'h0000_000A};

  always #5 clk_i = ~clk_i;

  pid_speed_loop #(.SAMPLE_CYCLES_P(SP)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .target_i(target_i), .feedback_i(fb), .feedback2_i(fb2),
    .freq_cmd_i(cmd_i), .run_i(run_i), .pid_disable_i(dis_i), .freq_o(freq_o),
    .reverse_o(reverse_o), .low_feedback_event_o(lo_o), .high_feedback_event_o(hi_o),
    .alarm_o(alarm_o), .fault_o(fault_o));

  fb_sensor_model sensor (.clk_i(clk_i), .fb_set_i(fb_set), .fb2_set_i(fb2_set),
    .slow_i(slow), .feedback_o(fb), .feedback2_o(fb2));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic ticks(input int n);
    repeat (n * SP) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [31:0] ctl(int m, bit i, bit rv_b, int s, bit clr);
    return {23'h00_0000, clr, 3'(s), rv_b, i, 3'(m)};
  endfunction

  function automatic int rnd(int n);
    return ($random(seed) & 32'h7FFF_FFFF) % n;
  endfunction

  task automatic sup(input int s, input bit run, input bit dis);
    wr(ADDR_CTRL, ctl(1, 0, 0, s, 0));
    run_i <= run;
    dis_i <= dis;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    final_report;
  end

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(ra[i], v);
      check(v, rv[i], "reset value");
    end
    rd(8'h40, v);
    check(v, 32'h0000_0000, "unmapped read");
    // random settings through the behavioural model, every mode and both signs
    for (int k = 0; k < 16; k++) begin
      md = k % 5;
      inv = rnd(2);
      rev = rnd(2);
      kp = rnd(2501);
      ceil = rnd(1001);
      kout = rnd(2501);
      bias = rnd(2001) - 1000;
      tg = rnd(10001);
      fv = rnd(10001);
      cm = rnd(10001);
      wr(ADDR_KP, 32'(kp));
      wr(ADDR_CEIL, 32'(ceil));
      wr(ADDR_KOUT, 32'(kout));
      wr(ADDR_BIAS, 32'(bias) & 32'h0000_FFFF);
      wr(ADDR_CTRL, ctl(md, inv, rev, 0, 0));
      target_i <= 16'(tg);
      fb_set <= 16'(fv);
      fb2_set <= 16'(rnd(10001));
      cmd_i <= 16'(cm);
      ticks(3);
      u = kp * (tg - fv) / 100;
      if (inv) u = -u;
      if (u > ceil * 10) u = ceil * 10;
      if (u < -ceil * 10) u = -ceil * 10;
      u = u * kout / 100 + bias * 10;
      f = (md == 0) ? cm : (md >= 3) ? cm + u : u;
      r = 1'b0;
      if (f < 0) begin
        r = rev;
        f = rev ? -f : 0;
      end
      if (f > 10000) f = 10000;
      check(32'(freq_o), 32'(f), "output frequency");
      check(32'(reverse_o), 32'(r), "reverse");
      rd(ADDR_DEV, v);
      check(v, 32'(tg - fv), "deviation monitor");
      rd(ADDR_FB2, v);
      check(v, 32'(fb2_set), "second feedback monitor");
    end
    // refused mode keeps the old one; read-only status ignores writes
    wr(ADDR_CTRL, ctl(4, 0, 0, 0, 0));
    wr(ADDR_CTRL, ctl(7, 1, 0, 0, 0));
    wr(ADDR_STATUS, 32'h0000_001F);
    rd(ADDR_CTRL, v);
    check(v, ctl(4, 1, 0, 0, 0), "mode refused");
    rd(ADDR_STATUS, v);
    check(v, 32'h0000_0000, "status write ignored");
    // integral alone, clamped at 0.1 %, then disabled by zero time
    wr(ADDR_KP, 32'h0000_0000);
    wr(ADDR_KOUT, 32'h0000_0064);
    wr(ADDR_CEIL, 32'h0000_03E8);
    wr(ADDR_BIAS, 32'h0000_0000);
    wr(ADDR_ILIM, 32'h0000_0001);
    wr(ADDR_TI, 32'h0000_0064);
    wr(ADDR_CTRL, ctl(1, 0, 0, 0, 0));
    target_i <= 16'h2710;
    fb_set <= 16'h0000;
    ticks(4);
    check(32'(freq_o), 32'd10, "integral clamp");
    wr(ADDR_TI, 32'h0000_0000);
    ticks(3);
    check(32'(freq_o), 32'd0, "integral off");
    wr(ADDR_KP, 32'h0000_0064);
    // low detection for selections 0, 1, 3, 4, 6 and 7, zero time: one tick qualifies
    wr(ADDR_LO_LVL, 32'h0000_0032);
    wr(ADDR_LO_TIME, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      sup(tbl[k][0], tbl[k][1], tbl[k][2]);
      fb_set <= 16'h03E8;
      ticks(3);
      check(32'(lo_o), 32'(tbl[k][3]), "low event");
      check(32'(alarm_o), 32'(tbl[k][4]), "alarm");
      fb_set <= 16'h1770;
      ticks(1);
      check(32'(lo_o | alarm_o), 32'd0, "back in range");
    end
    // timer restarts when the condition clears early; slewing sensor
    sup(0, 1, 0);
    slow <= 1'b1;
    wr(ADDR_LO_TIME, 32'h0000_0001);
    fb_set <= 16'h03E8;
    ticks(60);
    fb_set <= 16'h1770;
    ticks(6);
    fb_set <= 16'h03E8;
    ticks(60);
    check(32'(lo_o), 32'd0, "early low event");
    ticks(55);
    check(32'(lo_o), 32'd1, "qualified low event");
    slow <= 1'b0;
    fb_set <= 16'h1770;
    // high detection with fault: motor stopped, fault sticks until cleared
    wr(ADDR_HI_LVL, 32'h0000_003C);
    wr(ADDR_HI_TIME, 32'h0000_0000);
    sup(2, 1, 0);
    fb_set <= 16'h1B58;
    ticks(3);
    check(32'(fault_o), 32'd1, "fault");
    check(32'({hi_o, reverse_o, freq_o}), 32'h0000_0000, "stopped");
    fb_set <= 16'h1388;
    ticks(2);
    rd(ADDR_STATUS, v);
    check(v, 32'h0000_0008, "fault held");
    wr(ADDR_CTRL, ctl(1, 0, 0, 2, 1));
    ticks(1);
    check(32'(fault_o), 32'd0, "fault cleared");
    sup(0, 1, 0);
    fb_set <= 16'h1B58;
    ticks(3);
    check(32'(hi_o), 32'd1, "high event");
    // derivative on the second feedback: a drop gives a pulse of one sample
    wr(ADDR_KP, 32'h0000_0000);
    wr(ADDR_TD, 32'h0000_0001);
    wr(ADDR_CTRL, ctl(2, 0, 0, 0, 0));
    target_i <= 16'h0000;
    fb_set <= 16'h0000;
    fb2_set <= 16'h01F4;
    ticks(3);
    fb2_set <= 16'h0000;
    u = 0;
    repeat (3 * SP) begin
      @(posedge clk_i);
      #1 u += (freq_o == 16'h1388);
    end
    check(32'(u), 32'(SP), "derivative pulse");
    check(32'(freq_o), 32'h0000_0000, "derivative settled");
    // output filter of 0.01 s: each sample closes a tenth of the gap
    wr(ADDR_TD, 32'h0000_0000);
    wr(ADDR_KP, 32'h0000_0064);
    wr(ADDR_TF, 32'h0000_0001);
    wr(ADDR_CTRL, ctl(1, 0, 0, 0, 0));
    target_i <= 16'h03E8;
    u = 0;
    repeat (3 * SP) begin
      @(posedge clk_i);
      #1 u += (freq_o == 16'h0064);
    end
    check(32'(u), 32'(SP), "filter first step");
    f = 0;
    repeat (200) f += (1000 - f) / 10;
    ticks(80);
    check(32'(freq_o), 32'(f), "filter settled");
    final_report;
  end
endmodule // pid_speed_loop_with_feedback_check_bench
